// File: rtl/ccm_top.sv
// System clock control: mode registers, stop and wait modes, oscillator stop fallback.
`timescale 1ns/10ps
`default_nettype none
`include "ccm_params.svh"
module ccm_top #(
  parameter int STOP_TIMEOUT_CYC = `CCM_STOP_TIMEOUT_CYC,
  parameter int DIV_CNT_W = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic clock_reg_write_unlock_i,
  input wire logic periph_irq_i,
  input wire logic main_osc_input_i,
  output logic [7:0] reg_rdata_o,
  output logic stop_mode_o,
  output logic wait_mode_o,
  output logic cpu_clk_en_o,
  output logic main_osc_run_o,
  output logic sub_osc_run_o,
  output logic low_speed_osc_run_o,
  output logic main_fb_res_on_o,
  output logic sub_fb_res_on_o,
  output logic main_osc_pins_o,
  output logic sub_osc_pins_o,
  output logic shared_pins_gpio_o,
  output logic sys_clk_on_chip_o,
  output logic main_osc_stopped_o
);
  if (STOP_TIMEOUT_CYC < 2) begin : g_chk
    $error("ccm_top: STOP_TIMEOUT_CYC must be at least 2");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ccm_pkg::ccm_pwr_t pwr_ff;
  ccm_pkg::ccm_pwr_t nxt_pwr;
  ccm_pkg::ccm_byte_t cm1_ff;
  ccm_pkg::ccm_byte_t nxt_cm1;
  logic div8_ff;
  logic nxt_div8;
  logic mstop_ff;
  logic nxt_mstop;
  logic spin_ff;
  logic nxt_spin;
  logic sstop_ff;
  logic nxt_sstop;
  logic nodiv_ff;
  logic nxt_nodiv;
  logic [1:0] wake_ff;
  logic [1:0] nxt_wake;
  logic det_en_ff;
  logic nxt_det_en;
  logic det_irq_ff;
  logic nxt_det_irq;
  logic onchip_ff;
  logic nxt_onchip;
  ccm_pkg::ccm_byte_t rdata_ff;
  logic osc_silent;
  logic div_tick;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_ok = reg_wr_i & clock_reg_write_unlock_i;
  wire wr_aux = wr_ok & (reg_addr_i == `CCM_ADDR_AUX);
  wire wr_cm1 = wr_ok & (reg_addr_i == `CCM_ADDR_CM1);
  wire wr_cm3 = wr_ok & (reg_addr_i == `CCM_ADDR_CM3);
  wire wr_ocd = wr_ok & (reg_addr_i == `CCM_ADDR_OCD);
  wire in_run = (pwr_ff == ccm_pkg::CCM_RUN);
  wire in_wait = (pwr_ff == ccm_pkg::CCM_WAIT);
  wire in_stop = (pwr_ff == ccm_pkg::CCM_STOP);
  wire stop_enter = in_run & wr_cm1 & reg_wdata_i[`CCM_CM1_STOP];
  wire wait_enter = in_run & wr_cm3 & reg_wdata_i[`CCM_CM3_WAIT] & ~stop_enter;
  // The no-division choice written with the wait request applies at once.
  wire nodiv_entry = wait_enter & reg_wdata_i[`CCM_CM3_NODIV];
  wire mode_exit = ~in_run & periph_irq_i;
  // Codes 01 and 10 are not allowed; they behave as 00 on exit.
  wire wake_main = mode_exit & (wake_ff == `CCM_WAKE_MAIN);
  wire stopped_flag = det_en_ff & osc_silent;
  wire auto_switch = det_en_ff & det_irq_ff & osc_silent;

  // ----------------------------------------------------------------
  // Power mode sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      ccm_pkg::CCM_RUN: begin
        if (stop_enter) begin
          nxt_pwr = ccm_pkg::CCM_STOP;
        end else if (wait_enter) begin
          nxt_pwr = ccm_pkg::CCM_WAIT;
        end
      end
      ccm_pkg::CCM_WAIT: begin
        if (periph_irq_i) begin
          nxt_pwr = ccm_pkg::CCM_RUN;
        end
      end
      ccm_pkg::CCM_STOP: begin
        if (periph_irq_i) begin
          nxt_pwr = ccm_pkg::CCM_RUN;
        end
      end
      default: nxt_pwr = ccm_pkg::CCM_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // Control register one
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cm1 = cm1_ff;
    if (wr_cm1) begin
      nxt_cm1 = reg_wdata_i & `CCM_CM1_MASK;
      nxt_cm1[`CCM_CM1_MPIN] = reg_wdata_i[`CCM_CM1_MPIN] | cm1_ff[`CCM_CM1_MPIN];
      nxt_cm1[`CCM_CM1_LSOFF] = reg_wdata_i[`CCM_CM1_LSOFF] & ~onchip_ff;
    end
    if (nodiv_entry) begin
      nxt_cm1[`CCM_CM1_DIV_HI:`CCM_CM1_DIV_LO] = `CCM_DIV_NONE;
    end
    if (wake_main) begin
      nxt_cm1[`CCM_CM1_MPIN] = 1'b1;
    end
    if (nxt_onchip) begin
      nxt_cm1[`CCM_CM1_LSOFF] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary clock control bits
  // ----------------------------------------------------------------
  always_comb begin
    nxt_div8 = div8_ff;
    nxt_mstop = mstop_ff;
    nxt_spin = spin_ff;
    nxt_sstop = sstop_ff;
    if (wr_aux) begin
      nxt_div8 = reg_wdata_i[`CCM_AUX_DIV8];
      nxt_mstop = reg_wdata_i[`CCM_AUX_MSTOP];
      nxt_spin = reg_wdata_i[`CCM_AUX_SPIN] | spin_ff;
      nxt_sstop = reg_wdata_i[`CCM_AUX_SSTOP];
    end
    // Stop mode always resumes at a safe slow CPU clock.
    if (stop_enter) begin
      nxt_div8 = 1'b1;
    end
    if (nodiv_entry) begin
      nxt_div8 = 1'b0;
    end
    if (wake_main) begin
      nxt_mstop = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register three and detection register
  // ----------------------------------------------------------------
  always_comb begin
    nxt_nodiv = nodiv_ff;
    nxt_wake = wake_ff;
    if (wr_cm3) begin
      nxt_nodiv = reg_wdata_i[`CCM_CM3_NODIV];
      nxt_wake = reg_wdata_i[`CCM_CM3_WAKE_HI:`CCM_CM3_WAKE_LO];
    end
  end

  always_comb begin
    nxt_det_en = det_en_ff;
    nxt_det_irq = det_irq_ff;
    nxt_onchip = onchip_ff;
    if (wr_ocd) begin
      nxt_det_en = reg_wdata_i[`CCM_OCD_EN];
      nxt_det_irq = reg_wdata_i[`CCM_OCD_IRQ];
      nxt_onchip = reg_wdata_i[`CCM_OCD_ONCHIP] | (stopped_flag & onchip_ff);
    end
    if (wake_main) begin
      nxt_onchip = 1'b0;
    end
    // The fallback wins over any write or wake in the same cycle.
    if (auto_switch) begin
      nxt_onchip = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pwr_ff <= ccm_pkg::CCM_RUN;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cm1_ff <= `CCM_CM1_RST;
    end else begin
      cm1_ff <= nxt_cm1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div8_ff <= 1'(`CCM_AUX_RST >> `CCM_AUX_DIV8);
      mstop_ff <= 1'(`CCM_AUX_RST >> `CCM_AUX_MSTOP);
      spin_ff <= 1'(`CCM_AUX_RST >> `CCM_AUX_SPIN);
      sstop_ff <= 1'(`CCM_AUX_RST >> `CCM_AUX_SSTOP);
    end else begin
      div8_ff <= nxt_div8;
      mstop_ff <= nxt_mstop;
      spin_ff <= nxt_spin;
      sstop_ff <= nxt_sstop;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      nodiv_ff <= 1'(`CCM_CM3_RST >> `CCM_CM3_NODIV);
      wake_ff <= 2'(`CCM_CM3_RST >> `CCM_CM3_WAKE_LO);
    end else begin
      nodiv_ff <= nxt_nodiv;
      wake_ff <= nxt_wake;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      det_en_ff <= 1'(`CCM_OCD_RST >> `CCM_OCD_EN);
      det_irq_ff <= 1'(`CCM_OCD_RST >> `CCM_OCD_IRQ);
      onchip_ff <= 1'(`CCM_OCD_RST >> `CCM_OCD_ONCHIP);
    end else begin
      det_en_ff <= nxt_det_en;
      det_irq_ff <= nxt_det_irq;
      onchip_ff <= nxt_onchip;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] rd_cm1 = {cm1_ff[7:1], in_stop};
  wire [7:0] rd_cm3 = {wake_ff, nodiv_ff, 4'h0, in_wait};
  wire [7:0] rd_ocd = {4'h0, stopped_flag, onchip_ff, det_irq_ff, det_en_ff};
  wire [7:0] rd_aux = {1'b0, div8_ff, mstop_ff, spin_ff, sstop_ff, 3'h0};
  wire [7:0] rd_val = (reg_addr_i == `CCM_ADDR_CM1) ? rd_cm1 :
                      (reg_addr_i == `CCM_ADDR_CM3) ? rd_cm3 :
                      (reg_addr_i == `CCM_ADDR_OCD) ? rd_ocd :
                      (reg_addr_i == `CCM_ADDR_AUX) ? rd_aux : 8'h00;

  // Data is held only in the cycle after the read strobe.
  always_ff @(posedge clock_i) begin
    if (rst_i || !reg_rd_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rd_val;
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  ccm_osc_monitor #(
    .TIMEOUT(STOP_TIMEOUT_CYC)
  ) u_mon (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .osc_i(main_osc_input_i),
    .stopped_o(osc_silent)
  );

  ccm_cpu_div #(
    .CNT_W(DIV_CNT_W)
  ) u_div (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(in_run),
    .div8_i(div8_ff),
    .div_sel_i(cm1_ff[`CCM_CM1_DIV_HI:`CCM_CM1_DIV_LO]),
    .tick_o(div_tick)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = rdata_ff;
  assign stop_mode_o = in_stop;
  assign wait_mode_o = in_wait;
  assign cpu_clk_en_o = div_tick;
  assign main_osc_run_o = ~in_stop & ~mstop_ff;
  assign sub_osc_run_o = ~in_stop & ~sstop_ff;
  assign low_speed_osc_run_o = ~in_stop & ~cm1_ff[`CCM_CM1_LSOFF];
  assign main_fb_res_on_o = ~in_stop & ~cm1_ff[`CCM_CM1_MFB];
  assign sub_fb_res_on_o = ~in_stop & ~cm1_ff[`CCM_CM1_SFB];
  assign main_osc_pins_o = cm1_ff[`CCM_CM1_MPIN];
  assign sub_osc_pins_o = spin_ff;
  assign shared_pins_gpio_o = ~cm1_ff[`CCM_CM1_MPIN] & mstop_ff & ~spin_ff & sstop_ff;
  assign sys_clk_on_chip_o = onchip_ff;
  assign main_osc_stopped_o = stopped_flag;
endmodule
`default_nettype wire

// File: shared/ccm_params.svh
// Register map, field positions, reset values and timing constants of the clock control.
`ifndef CCM_PARAMS_SVH
`define CCM_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCM_ADDR_AUX 8'h06
`define CCM_ADDR_CM1 8'h07
`define CCM_ADDR_CM3 8'h09
`define CCM_ADDR_OCD 8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCM_CM1_STOP 0
`define CCM_CM1_MFB 1
`define CCM_CM1_SFB 2
`define CCM_CM1_MPIN 3
`define CCM_CM1_LSOFF 4
`define CCM_CM1_RSV 5
`define CCM_CM1_DIV_LO 6
`define CCM_CM1_DIV_HI 7
`define CCM_CM3_WAIT 0
`define CCM_CM3_NODIV 5
`define CCM_CM3_WAKE_LO 6
`define CCM_CM3_WAKE_HI 7
`define CCM_OCD_EN 0
`define CCM_OCD_IRQ 1
`define CCM_OCD_ONCHIP 2
`define CCM_OCD_FLAG 3
`define CCM_AUX_SSTOP 3
`define CCM_AUX_SPIN 4
`define CCM_AUX_MSTOP 5
`define CCM_AUX_DIV8 6

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define CCM_CM1_RST 8'h20
`define CCM_CM1_MASK 8'hFE
`define CCM_CM3_RST 8'h00
`define CCM_OCD_RST 8'h04
`define CCM_AUX_RST 8'h68
`define CCM_WAKE_MAIN 2'b11
`define CCM_DIV_NONE 2'b00
`define CCM_DIV_LIM_1 4'h0
`define CCM_DIV_LIM_2 4'h1
`define CCM_DIV_LIM_4 4'h3
`define CCM_DIV_LIM_8 4'h7
`define CCM_DIV_LIM_16 4'hF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCM_CLK_MHZ 250
`define CCM_STOP_TIMEOUT_NS 1000
`define CCM_STOP_TIMEOUT_CYC ((`CCM_STOP_TIMEOUT_NS * `CCM_CLK_MHZ + 999) / 1000)

`endif

// File: shared/ccm_pkg.sv
// Types shared by the clock control modules.
package ccm_pkg;
  typedef enum logic [1:0] {
    CCM_RUN,
    CCM_WAIT,
    CCM_STOP
  } ccm_pwr_t;
  typedef logic [7:0] ccm_byte_t;
endpackage

// File: rtl/ccm_osc_monitor.sv
// Main oscillator activity monitor: flags a stop after a silent interval.
`timescale 1ns/10ps
`default_nettype none
module ccm_osc_monitor #(
  parameter int TIMEOUT = 250
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic osc_i,
  output logic stopped_o
);
  if (TIMEOUT < 2) begin : g_chk
    $error("ccm_osc_monitor: TIMEOUT must be at least 2");
  end

  localparam int CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic [CW-1:0] cnt_ff;
  logic stopped_ff;
  wire toggled = sync2_ff ^ prev_ff;
  wire expired = (cnt_ff == LIMIT);

  // The oscillator level passes two sync flops and is compared with its previous sample to detect a toggle.
  always_ff @(posedge clock_i) begin
    sync1_ff <= osc_i;
    sync2_ff <= sync1_ff;
    prev_ff <= sync2_ff;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      stopped_ff <= 1'b0;
    end else if (toggled) begin
      cnt_ff <= '0;
      stopped_ff <= 1'b0;
    end else if (expired) begin
      stopped_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  assign stopped_o = stopped_ff;
endmodule
`default_nettype wire

// File: rtl/ccm_cpu_div.sv
// CPU clock divider producing a one-cycle enable per divided period.
`timescale 1ns/10ps
`default_nettype none
`include "ccm_params.svh"
module ccm_cpu_div #(
  parameter int CNT_W = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic div8_i,
  input wire logic [1:0] div_sel_i,
  output logic tick_o
);
  if (CNT_W < 4) begin : g_chk
    $error("ccm_cpu_div: CNT_W must be at least 4");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic [3:0] limit;

  always_comb begin
    if (div8_i) begin
      limit = `CCM_DIV_LIM_8;
    end else begin
      unique case (div_sel_i)
        2'b00: limit = `CCM_DIV_LIM_1;
        2'b01: limit = `CCM_DIV_LIM_2;
        2'b10: limit = `CCM_DIV_LIM_4;
        2'b11: limit = `CCM_DIV_LIM_16;
      endcase
    end
  end

  wire at_limit = (cnt_ff >= CNT_W'(limit));

  // A ratio change restarts cleanly because the compare is at or above.
  always_ff @(posedge clock_i) begin
    if (rst_i || (run_i && at_limit)) begin
      cnt_ff <= '0;
    end else if (run_i) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  assign tick_o = run_i & at_limit;
endmodule
`default_nettype wire

// File: dv/ccm_resonator.sv
// Behavioural resonator on the main oscillator pin of the clock control.
`timescale 1ns/10ps
`default_nettype none
module ccm_resonator (
  input wire logic run_i,
  input wire logic fail_i,
  output logic osc_o
);
  // ----------------------------------------------------------------
  // Oscillation
  // ----------------------------------------------------------------
  // The period is unrelated to the system clock, so the design's synchroniser is exercised.
  initial begin
    osc_o = 1'b0;
  end
  always begin
    #3.3;
    if (run_i && !fail_i) begin
      osc_o = ~osc_o;
    end
  end
endmodule
`default_nettype wire

// File: dv/ccm_top_chk.sv
// Concurrent checks on the ports of the clock control top level.
`timescale 1ns/10ps
`default_nettype none
`include "ccm_params.svh"
module ccm_top_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic clock_reg_write_unlock_i,
  input wire logic periph_irq_i,
  input wire logic stop_mode_o,
  input wire logic wait_mode_o,
  input wire logic cpu_clk_en_o,
  input wire logic main_osc_run_o,
  input wire logic sub_osc_run_o,
  input wire logic low_speed_osc_run_o,
  input wire logic main_fb_res_on_o,
  input wire logic sub_fb_res_on_o,
  input wire logic main_osc_pins_o,
  input wire logic sub_osc_pins_o,
  input wire logic shared_pins_gpio_o,
  input wire logic sys_clk_on_chip_o,
  input wire logic main_osc_stopped_o
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire logic run_st = !stop_mode_o && !wait_mode_o;
  wire logic wr_cm1 = reg_wr_i && clock_reg_write_unlock_i && reg_addr_i == `CCM_ADDR_CM1;
  wire logic lk_cm3 = reg_wr_i && !clock_reg_write_unlock_i && reg_addr_i == `CCM_ADDR_CM3;
  AST_STOP_OFF: assert property (stop_mode_o |-> !(main_osc_run_o | sub_osc_run_o | low_speed_osc_run_o | cpu_clk_en_o))
    else $error("clock running in stop mode");
  AST_STOP_FB: assert property (stop_mode_o |-> !main_fb_res_on_o && !sub_fb_res_on_o)
    else $error("feedback resistor connected in stop mode");
  AST_STOP_ENTRY: assert property (wr_cm1 && reg_wdata_i[0] && run_st |=> stop_mode_o)
    else $error("stop write did not enter stop mode");
  AST_LOCKED: assert property (lk_cm3 && reg_wdata_i[0] && run_st |=> !wait_mode_o)
    else $error("locked write entered wait mode");
  AST_WAIT_CPU: assert property (wait_mode_o && $past(wait_mode_o) |-> !cpu_clk_en_o && $stable(main_osc_run_o)
    && $stable(sub_osc_run_o)) else $error("wait mode disturbed the wrong clock");
  AST_WAKE: assert property (!run_st && periph_irq_i |=> run_st)
    else $error("interrupt did not end wait or stop");
  AST_PIN_STICKY: assert property (main_osc_pins_o |=> main_osc_pins_o)
    else $error("main pin enable returned to zero");
  AST_LS_ON: assert property (sys_clk_on_chip_o && run_st ##1 sys_clk_on_chip_o && run_st |-> low_speed_osc_run_o)
    else $error("low-speed oscillator off with on-chip clock");
  AST_GPIO: assert property (shared_pins_gpio_o |-> !(main_osc_pins_o | sub_osc_pins_o | main_osc_run_o | sub_osc_run_o))
    else $error("shared pins free while an oscillator uses them");
  AST_HOLD_ONCHIP: assert property (main_osc_stopped_o && sys_clk_on_chip_o && run_st |=> sys_clk_on_chip_o)
    else $error("on-chip select cleared while main clock stopped");
  COV_WAIT: cover property ($rose(wait_mode_o));
  COV_STOP: cover property ($rose(stop_mode_o));
  COV_AUTO: cover property ($rose(main_osc_stopped_o) ##[0:4] sys_clk_on_chip_o);
  COV_GPIO: cover property (shared_pins_gpio_o);
endmodule
bind ccm_top ccm_top_chk ccm_top_chk_inst (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .clock_reg_write_unlock_i(clock_reg_write_unlock_i),
  .periph_irq_i(periph_irq_i), .stop_mode_o(stop_mode_o), .wait_mode_o(wait_mode_o), .cpu_clk_en_o(cpu_clk_en_o),
  .main_osc_run_o(main_osc_run_o), .sub_osc_run_o(sub_osc_run_o), .low_speed_osc_run_o(low_speed_osc_run_o),
  .main_fb_res_on_o(main_fb_res_on_o), .sub_fb_res_on_o(sub_fb_res_on_o), .main_osc_pins_o(main_osc_pins_o),
  .sub_osc_pins_o(sub_osc_pins_o), .shared_pins_gpio_o(shared_pins_gpio_o), .sys_clk_on_chip_o(sys_clk_on_chip_o),
  .main_osc_stopped_o(main_osc_stopped_o));
`default_nettype wire

// File: dv/ccm_top_bench.sv
// Self-checking testbench of the clock control top level.
`timescale 1ns/10ps
`default_nettype none
`include "ccm_params.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module ccm_top_bench;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  logic clock_i, rst_i, reg_wr_i, reg_rd_i, unlock, irq, fail, osc;
  logic [7:0] reg_addr_i, reg_wdata_i, rdata;
  logic stop_m, wait_m, cpu_en, main_run, sub_run, ls_run, mfb, sfb, mpins, spins, gpio, onchip, stopped;
  int err_count, compares;
  ccm_top #(.STOP_TIMEOUT_CYC(8), .DIV_CNT_W(4)) ccm_top_inst (.clock_i(clock_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .clock_reg_write_unlock_i(unlock), .periph_irq_i(irq), .main_osc_input_i(osc), .reg_rdata_o(rdata),
    .stop_mode_o(stop_m), .wait_mode_o(wait_m), .cpu_clk_en_o(cpu_en), .main_osc_run_o(main_run),
    .sub_osc_run_o(sub_run), .low_speed_osc_run_o(ls_run), .main_fb_res_on_o(mfb), .sub_fb_res_on_o(sfb),
    .main_osc_pins_o(mpins), .sub_osc_pins_o(spins), .shared_pins_gpio_o(gpio), .sys_clk_on_chip_o(onchip),
    .main_osc_stopped_o(stopped));
  ccm_resonator ccm_resonator_inst (.run_i(main_run), .fail_i(fail), .osc_o(osc));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic settle();
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] ex);
    logic [7:0] d;
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 d = rdata;
    `CHK(nm, ex, d & m)
  endtask
  task automatic wake();
    @(posedge clock_i);
    irq <= 1'b1;
    @(posedge clock_i);
    irq <= 1'b0;
    settle();
  endtask
  task automatic count_chk(input logic [7:0] ex);
    logic [7:0] n;
    n = 8'h00;
    repeat (20) @(posedge clock_i);
    repeat (64) begin
      @(posedge clock_i);
      #1 if (cpu_en === 1'b1) n++;
    end
    `CHK("cpu pulses", ex, n)
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_lock();
    `CHK("gpio", 1'b1, gpio);
    count_chk(8'h08);
    rchk("ocd", `CCM_ADDR_OCD, 8'hFF, 8'h04);
    rchk("unmapped", 8'h3F, 8'hFF, 8'h00);
    wr(`CCM_ADDR_CM1, 8'hA6);
    wr(`CCM_ADDR_CM3, 8'h01);
    settle();
    `CHK("locked wait", 1'b0, wait_m);
    rchk("locked cm1", `CCM_ADDR_CM1, 8'hFF, 8'h20);
  endtask
  task automatic t_cm1_bits();
    wr(`CCM_ADDR_CM1, 8'h26);
    settle();
    `CHK("fb off", 2'b00, {mfb, sfb});
    wr(`CCM_ADDR_CM1, 8'h30);
    settle();
    `CHK("fb on", 2'b11, {mfb, sfb});
    `CHK("ls run", 1'b1, ls_run);
    rchk("ls off", `CCM_ADDR_CM1, 8'hFF, 8'h20);
  endtask
  task automatic t_divider();
    wr(`CCM_ADDR_AUX, 8'h28);
    for (int i = 0; i < 4; i++) begin
      wr(`CCM_ADDR_CM1, {i[1:0], 6'h20});
      count_chk((i == 3) ? 8'h04 : (8'h40 >> i));
    end
    wr(`CCM_ADDR_AUX, 8'h68);
    count_chk(8'h08);
  endtask
  task automatic t_wait_nodiv();
    wr(`CCM_ADDR_CM3, 8'h21);
    settle();
    `CHK("wait", 3'b101, {wait_m, cpu_en, ls_run});
    wake();
    `CHK("wait end", 1'b0, wait_m);
    `CHK("keep clock", 1'b1, onchip);
    rchk("wait bit", `CCM_ADDR_CM3, 8'hFF, 8'h20);
    rchk("div field", `CCM_ADDR_CM1, 8'hC0, 8'h00);
    rchk("div8", `CCM_ADDR_AUX, 8'h40, 8'h00);
  endtask
  task automatic t_pin_wake_stop();
    wr(`CCM_ADDR_CM1, 8'h28);
    wr(`CCM_ADDR_CM1, 8'h20);
    settle();
    `CHK("pins", 2'b10, {mpins, gpio});
    rchk("pin sticky", `CCM_ADDR_CM1, 8'hFF, 8'h28);
    wr(`CCM_ADDR_CM3, 8'hC1);
    settle();
    wake();
    `CHK("wake main", 2'b10, {main_run, onchip});
    wr(`CCM_ADDR_CM1, 8'h29);
    settle();
    `CHK("stop", 6'b100000, {stop_m, mfb, sfb, main_run, ls_run, cpu_en});
    wake();
    `CHK("stop end", 2'b01, {stop_m, main_run});
  endtask
  task automatic t_detect();
    repeat (30) @(posedge clock_i);
    wr(`CCM_ADDR_OCD, 8'h03);
    settle();
    `CHK("running", 2'b00, {stopped, onchip});
    fail <= 1'b1;
    for (int i = 0; i < 60 && stopped !== 1'b1; i++) @(posedge clock_i);
    settle();
    `CHK("auto switch", 2'b11, {stopped, onchip});
    wr(`CCM_ADDR_OCD, 8'h01);
    rchk("hold onchip", `CCM_ADDR_OCD, 8'hFF, 8'h0D);
    wr(`CCM_ADDR_OCD, 8'h00);
    settle();
    `CHK("flag off", 1'b0, stopped);
    rchk("ocd off", `CCM_ADDR_OCD, 8'hFF, 8'h04);
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    tally_and_finish();
  end
  initial begin
    err_count = 0;
    compares = 0;
    rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    unlock = 1'b0;
    irq = 1'b0;
    fail = 1'b0;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    settle();
    t_reset_lock();
    unlock <= 1'b1;
    t_cm1_bits();
    t_divider();
    t_wait_nodiv();
    t_pin_wake_stop();
    t_detect();
    tally_and_finish();
  end
endmodule
`default_nettype wire
